// ### pkg/xpc_cfg.svh
// Constants of the crosspoint serial configuration link
`ifndef XPC_CFG_SVH
`define XPC_CFG_SVH
// ----------------------------------------------------------------
// Matrix geometry
// ----------------------------------------------------------------
`define XPC_NOUT 4
`define XPC_SELW 3
`define XPC_FIELD_BITS 4
`define XPC_FRAME_BITS 16
`define XPC_FLD_OFF_BIT 3
// ----------------------------------------------------------------
// Addressed word layout, bit 0 first on the wire
// ----------------------------------------------------------------
`define XPC_AWORD_BITS 6
`define XPC_AW_OUT_LSB 0
`define XPC_AW_OUT_W 2
`define XPC_AW_SEL_LSB 2
`define XPC_AW_OFF_BIT 5
// ----------------------------------------------------------------
// Reset and broadcast values of a matrix entry
// ----------------------------------------------------------------
`define XPC_SEL_RST 3'h0
`define XPC_OFF_RST 1'b1
`define XPC_SEL_BCAST 3'h0
`define XPC_OFF_BCAST 1'b0
// ----------------------------------------------------------------
// Controller timing in system clock cycles
// ----------------------------------------------------------------
`define XPC_SCLK_HALF 6
`define XPC_CFG_CYCLES 4
// ----------------------------------------------------------------
// Controller register map (byte addresses) and control bits
// ----------------------------------------------------------------
`define XPC_REG_CTRL 4'h0
`define XPC_REG_DATA 4'h4
`define XPC_REG_STAT 4'h8
`define XPC_REG_RX 4'hc
`define XPC_CTRL_GO 0
`define XPC_CTRL_MODE 1
`define XPC_CTRL_RST 2
`define XPC_CTRL_BCAST 3
`define XPC_CTRL_AUTO 4
`define XPC_CTRL_CFG 5
`define XPC_CTRL_RESET 6'h04
`endif

// ### pkg/xpc_pkg.sv
// Types shared by both ends of the crosspoint configuration link
`include "xpc_cfg.svh"
package xpc_pkg;
  typedef logic [`XPC_SELW-1:0] xpc_sel_t;
  typedef struct packed {
    logic off;
    xpc_sel_t sel;
  } xpc_field_t;
  typedef enum logic [1:0] {
    XPC_IDLE = 2'b00,
    XPC_LEAD = 2'b01,
    XPC_SHIFT = 2'b11,
    XPC_CONF = 2'b10
  } xpc_state_t;
endpackage

// ### pkg/xpc_link_if.sv
// Serial control pins between controller and crosspoint
`timescale 1ns/10ps
`default_nettype none
interface xpc_link_if;
  logic sclk;
  logic cs_n;
  logic sdi;
  logic sdo;
  logic cfg;
  logic mode;
  logic rst;
  logic broadcast_pin;
  modport host (
    output sclk, cs_n, sdi, cfg, mode, rst, broadcast_pin,
    input sdo
  );
  modport dev (
    input sclk, cs_n, sdi, cfg, mode, rst, broadcast_pin,
    output sdo
  );
endinterface
`default_nettype wire

// ### hw/xpc_sync.sv
// Two flip-flop level synchroniser
`timescale 1ns/10ps
`default_nettype none
module xpc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule
`default_nettype wire

// ### hw/xpc_dev.sv
// Crosspoint end: load shift register and switch matrix registers
`timescale 1ns/10ps
`default_nettype none
`include "xpc_cfg.svh"
module xpc_dev
  import xpc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  xpc_link_if.dev link,
  output logic [`XPC_NOUT*`XPC_SELW-1:0] sel_o,
  output logic [`XPC_NOUT-1:0] off_o,
  output logic pending_o
);

  // ----------------------------------------------------------------
  // Field decode helpers
  // ----------------------------------------------------------------
  function automatic xpc_field_t frame_field(
    input logic [`XPC_FRAME_BITS-1:0] frame,
    input int idx
  );
    xpc_field_t f;
    f.sel = frame[idx*`XPC_FIELD_BITS +: `XPC_SELW];
    f.off = frame[idx*`XPC_FIELD_BITS + `XPC_FLD_OFF_BIT];
    return f;
  endfunction

  function automatic xpc_field_t word_field(
    input logic [`XPC_AWORD_BITS-1:0] word
  );
    xpc_field_t f;
    f.sel = word[`XPC_AW_SEL_LSB +: `XPC_SELW];
    f.off = word[`XPC_AW_OFF_BIT];
    return f;
  endfunction

  function automatic xpc_field_t rst_field();
    xpc_field_t f;
    f.sel = `XPC_SEL_RST;
    f.off = `XPC_OFF_RST;
    return f;
  endfunction

  function automatic xpc_field_t bcast_field();
    xpc_field_t f;
    f.sel = `XPC_SEL_BCAST;
    f.off = `XPC_OFF_BCAST;
    return f;
  endfunction

  // ----------------------------------------------------------------
  // Link domain: reset taken from the reset pin
  // ----------------------------------------------------------------
  logic lrst;
  logic armed_q;
  logic [`XPC_FRAME_BITS-1:0] sr_q;
  logic tgl_q;
  logic sdo_q;

  xpc_sync #(
    .WIDTH(1)
  ) u_lrst_sync (
    .clk_i(link.sclk),
    .rst_i(1'b0),
    .d_i(link.rst),
    .q_o(lrst)
  );

  // Select is sampled on the rising edge here; shifting also needs it low at the falling edge
  always_ff @(posedge link.sclk) begin
    if (lrst) begin
      armed_q <= 1'b0;
    end else begin
      armed_q <= ~link.cs_n;
    end
  end

  // Bit 0 of the frame is the first in and ends up in sr_q[0]
  always_ff @(negedge link.sclk) begin
    if (lrst) begin
      sr_q <= '0;
      tgl_q <= 1'b0;
    end else if (armed_q && !link.cs_n) begin
      sr_q <= {link.sdi, sr_q[`XPC_FRAME_BITS-1:1]};
      tgl_q <= ~tgl_q;
    end
  end

  // Bit about to leave the load register, driven on the rising edge
  always_ff @(posedge link.sclk) begin
    if (lrst) begin
      sdo_q <= 1'b0;
    end else begin
      sdo_q <= sr_q[0];
    end
  end

  assign link.sdo = sdo_q;

  // ----------------------------------------------------------------
  // System domain: pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0] pin_s;
  logic cfg_s;
  logic rst_s;
  logic bc_s;
  logic mode_s;
  logic tgl_s;

  xpc_sync #(
    .WIDTH(5)
  ) u_pin_sync (
    .clk_i(clk_sys_i),
    .rst_i(sys_rst_i),
    .d_i({tgl_q, link.mode, link.broadcast_pin, link.rst, link.cfg}),
    .q_o(pin_s)
  );

  assign cfg_s = pin_s[0];
  assign rst_s = pin_s[1];
  assign bc_s = pin_s[2];
  assign mode_s = pin_s[3];
  assign tgl_s = pin_s[4];

  // ----------------------------------------------------------------
  // New-data tracking
  // ----------------------------------------------------------------
  logic cfg_prev_q;
  logic tgl_seen_q;
  logic fresh_q;
  logic cfg_rise;
  logic new_bit;

  assign cfg_rise = cfg_s & ~cfg_prev_q;
  assign new_bit = tgl_s ^ tgl_seen_q;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      cfg_prev_q <= 1'b0;
      tgl_seen_q <= 1'b0;
    end else begin
      cfg_prev_q <= cfg_s;
      tgl_seen_q <= tgl_s;
    end
  end

  // A bit arriving with the configure edge keeps data pending
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || rst_s) begin
      fresh_q <= 1'b0;
    end else if (new_bit) begin
      fresh_q <= 1'b1;
    end else if (cfg_rise) begin
      fresh_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Switch matrix registers
  // ----------------------------------------------------------------
  xpc_field_t mat_q [`XPC_NOUT];
  logic [`XPC_AWORD_BITS-1:0] aword;
  logic [`XPC_AW_OUT_W-1:0] aout;

  // Addressed word is the last six bits shifted in
  assign aword = sr_q[`XPC_FRAME_BITS-1 -: `XPC_AWORD_BITS];
  assign aout = aword[`XPC_AW_OUT_LSB +: `XPC_AW_OUT_W];

  // Load register is static while configure is high
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || rst_s) begin
      for (int i = 0; i < `XPC_NOUT; i++) begin
        mat_q[i] <= rst_field();
      end
    end else if (bc_s) begin
      for (int i = 0; i < `XPC_NOUT; i++) begin
        mat_q[i] <= bcast_field();
      end
    end else if (cfg_rise && fresh_q) begin
      if (mode_s) begin
        mat_q[aout] <= word_field(aword);
      end else begin
        for (int i = 0; i < `XPC_NOUT; i++) begin
          mat_q[i] <= frame_field(sr_q, i);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < `XPC_NOUT; i++) begin
      sel_o[i*`XPC_SELW +: `XPC_SELW] = mat_q[i].sel;
      off_o[i] = mat_q[i].off;
    end
  end

  assign pending_o = fresh_q;
endmodule
`default_nettype wire

// ### hw/xpc_host.sv
// Controller end: Avalon-MM registers driving the serial pins
//
// Our own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "xpc_cfg.svh"
module xpc_host
  import xpc_pkg::*;
#(
  parameter int NDEV = 1,
  parameter int HALF = `XPC_SCLK_HALF,
  parameter int CFG_CYC = `XPC_CFG_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  xpc_link_if.host link
);

  // ----------------------------------------------------------------
  // Avalon slave
  // ----------------------------------------------------------------
  logic wait_q;
  logic [31:0] rdata_q;
  logic [5:0] ctrl_q;
  logic [31:0] data_q;
  logic [31:0] rx_q;
  logic go_q;
  logic cfg_req_q;
  logic wr_ev;
  xpc_state_t state_q;

  assign wr_ev = avs_write_i & ~wait_q;

  function automatic logic [31:0] rd_mux(input logic [3:0] a);
    case (a)
      `XPC_REG_CTRL: rd_mux = {26'h0, ctrl_q};
      `XPC_REG_DATA: rd_mux = data_q;
      `XPC_REG_STAT: rd_mux = {31'h0,
        (state_q != XPC_IDLE) | go_q | cfg_req_q};
      `XPC_REG_RX: rd_mux = rx_q;
      default: rd_mux = 32'h0;
    endcase
  endfunction

  // One wait cycle for every access
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0;
    end else begin
      wait_q <= ~((avs_read_i | avs_write_i) & wait_q);
      if (avs_read_i && wait_q) begin
        rdata_q <= rd_mux(avs_address_i);
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ctrl_q <= `XPC_CTRL_RESET;
      data_q <= 32'h0;
    end else if (wr_ev && avs_address_i == `XPC_REG_CTRL) begin
      ctrl_q <= avs_writedata_i[5:0] & 6'h1e;
    end else if (wr_ev && avs_address_i == `XPC_REG_DATA) begin
      data_q <= avs_writedata_i;
    end
  end

  assign avs_readdata_o = rdata_q;
  assign avs_waitrequest_o = wait_q;

  // ----------------------------------------------------------------
  // Serial clock divider, free running
  // ----------------------------------------------------------------
  logic [7:0] div_q;
  logic sclk_q;
  logic tick;
  logic rise_ev;
  logic fall_ev;

  assign tick = div_q == 8'(HALF - 1);
  assign rise_ev = tick & ~sclk_q;
  assign fall_ev = tick & sclk_q;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      div_q <= 8'h0;
      sclk_q <= 1'b0;
    end else if (tick) begin
      div_q <= 8'h0;
      sclk_q <= ~sclk_q;
    end else begin
      div_q <= div_q + 8'h1;
    end
  end

  // ----------------------------------------------------------------
  // Transfer sequencer
  // ----------------------------------------------------------------
  logic sdo_s;
  logic cs_n_q;
  logic sdi_q;
  logic cfg_q;
  logic [31:0] sh_q;
  logic [5:0] cnt_q;
  logic [7:0] ccnt_q;
  logic [5:0] len;
  logic cs_up_q;

  xpc_sync #(
    .WIDTH(1)
  ) u_sdo_sync (
    .clk_i(clk_sys_i),
    .rst_i(sys_rst_i),
    .d_i(link.sdo),
    .q_o(sdo_s)
  );

  assign len = ctrl_q[`XPC_CTRL_MODE] ? 6'(`XPC_AWORD_BITS)
    : 6'(`XPC_FRAME_BITS * NDEV);

  // Set wins over the clear when both fall in one cycle
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      go_q <= 1'b0;
      cfg_req_q <= 1'b0;
    end else begin
      if (wr_ev && avs_address_i == `XPC_REG_CTRL
          && avs_writedata_i[`XPC_CTRL_GO]) begin
        go_q <= 1'b1;
      end else if (state_q == XPC_IDLE && fall_ev) begin
        go_q <= 1'b0;
      end
      if (wr_ev && avs_address_i == `XPC_REG_CTRL
          && avs_writedata_i[`XPC_CTRL_CFG]) begin
        cfg_req_q <= 1'b1;
      end else if (state_q == XPC_IDLE && !go_q) begin
        cfg_req_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state_q <= XPC_IDLE;
      cs_n_q <= 1'b1;
      sdi_q <= 1'b0;
      cfg_q <= 1'b0;
      sh_q <= 32'h0;
      cnt_q <= 6'h0;
      ccnt_q <= 8'h0;
      rx_q <= 32'h0;
      cs_up_q <= 1'b0;
    end else begin
      // Select rises a cycle after the last fall, never with it
      cs_up_q <= 1'b0;
      if (cs_up_q) begin
        cs_n_q <= 1'b1;
      end
      case (state_q)
        XPC_IDLE: begin
          if (go_q && fall_ev) begin
            cs_n_q <= 1'b0;
            sh_q <= data_q;
            cnt_q <= 6'h0;
            state_q <= XPC_LEAD;
          end else if (cfg_req_q && !go_q) begin
            ccnt_q <= 8'h0;
            state_q <= XPC_CONF;
          end
        end
        XPC_LEAD: begin
          if (rise_ev) begin
            sdi_q <= sh_q[0];
            sh_q <= {1'b0, sh_q[31:1]};
            state_q <= XPC_SHIFT;
          end
        end
        XPC_SHIFT: begin
          if (fall_ev) begin
            rx_q <= {sdo_s, rx_q[31:1]};
            cnt_q <= cnt_q + 6'h1;
            if (cnt_q + 6'h1 == len) begin
              cs_up_q <= 1'b1;
              ccnt_q <= 8'h0;
              state_q <= ctrl_q[`XPC_CTRL_AUTO] ? XPC_CONF : XPC_IDLE;
            end
          end else if (rise_ev) begin
            sdi_q <= sh_q[0];
            sh_q <= {1'b0, sh_q[31:1]};
          end
        end
        XPC_CONF: begin
          cfg_q <= 1'b1;
          ccnt_q <= ccnt_q + 8'h1;
          if (ccnt_q == 8'(CFG_CYC)) begin
            cfg_q <= 1'b0;
            state_q <= XPC_IDLE;
          end
        end
        default: state_q <= XPC_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------
  assign link.sclk = sclk_q;
  assign link.cs_n = cs_n_q;
  assign link.sdi = sdi_q;
  assign link.cfg = cfg_q;
  assign link.mode = ctrl_q[`XPC_CTRL_MODE];
  assign link.rst = ctrl_q[`XPC_CTRL_RST];
  assign link.broadcast_pin = ctrl_q[`XPC_CTRL_BCAST];
endmodule
`default_nettype wire

// ### testbench/xpc_link_checker.sv
// Assertions on the crosspoint configuration link
`timescale 1ns/10ps
`default_nettype none
module xpc_link_checker (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic cfg,
  input wire logic mode,
  input wire logic rst,
  input wire logic broadcast_pin,
  input wire logic [11:0] sel_o,
  input wire logic [3:0] off_o,
  input wire logic pending_o
);
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);
  // ----------------------------------------
  // Cycles since a matrix-writing cause
  // ----------------------------------------
  logic [3:0] quiet_q;
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || cfg || rst || broadcast_pin) begin
      quiet_q <= 4'h0;
    end else if (quiet_q != 4'hf) begin
      quiet_q <= quiet_q + 4'h1;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_rst;
    rst [*5] |-> off_o == 4'hf && sel_o == 12'h000;
  endproperty
  a_rst: assert property (p_rst)
    else $error("outputs not off under reset pin");
  property p_broadcast_pin;
    (broadcast_pin && !rst) [*5] |-> off_o == 4'h0 && sel_o == 12'h000;
  endproperty
  a_broadcast_pin: assert property (p_broadcast_pin)
    else $error("outputs not on input 0 under broadcast");
  property p_both;
    (broadcast_pin && rst) [*5] |-> off_o == 4'hf;
  endproperty
  a_both: assert property (p_both)
    else $error("broadcast beat reset");
  property p_quiet;
    $changed({sel_o, off_o}) |-> quiet_q < 4'h6;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("matrix changed without configure");
  property p_cfg_low;
    !cs_n |-> !cfg;
  endproperty
  a_cfg_low: assert property (p_cfg_low)
    else $error("configure high while shifting");
  property p_cs_edge;
    $changed(cs_n) |-> !sclk;
  endproperty
  a_cs_edge: assert property (p_cs_edge)
    else $error("select moved while serial clock high");
  property p_sdi;
    $changed(sdi) |-> sclk;
  endproperty
  a_sdi: assert property (p_sdi)
    else $error("data moved near falling edge");
  property p_cfg_len;
    $rose(cfg) |-> cfg [*4] ##1 !cfg;
  endproperty
  a_cfg_len: assert property (p_cfg_len)
    else $error("configure pulse length wrong");
  property p_addr_rise;
    $rose(cs_n) && mode |-> ##[1:20] $rose(sclk);
  endproperty
  a_addr_rise: assert property (p_addr_rise)
    else $error("no clock rise after select in addressed mode");
  c_addr: cover property ($rose(cfg) && mode);
  c_broadcast_pin: cover property (broadcast_pin && !rst);
  c_pend: cover property ($rose(pending_o));
endmodule
`default_nettype wire

// ### testbench/test_crosspoint_serial_config.sv
// Bench joining controller and crosspoint ends
`timescale 1ns/10ps
`default_nettype none
`include "xpc_cfg.svh"
module test_crosspoint_serial_config;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [11:0] sel;
  logic [3:0] off;
  logic pend;
  logic [11:0] exp_sel = 12'h000;
  logic [3:0] exp_off = 4'hf;
  logic [31:0] rng = 32'h9;
  logic [31:0] q;
  logic [15:0] f;
  logic [15:0] prev;
  int fails = 0;
  int total_checks = 0;
  int cyc = 0;
  xpc_link_if link();
  xpc_host u_xpc_host (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .avs_address_i(avs_address), .avs_read_i(avs_read),
    .avs_write_i(avs_write), .avs_writedata_i(avs_writedata),
    .avs_readdata_o(avs_readdata), .avs_waitrequest_o(avs_waitrequest),
    .link(link));
  xpc_dev u_xpc_dev (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .link(link), .sel_o(sel), .off_o(off), .pending_o(pend));
  xpc_link_checker u_xpc_link_checker (.clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i), .sclk(link.sclk), .cs_n(link.cs_n),
    .sdi(link.sdi), .cfg(link.cfg), .mode(link.mode), .rst(link.rst),
    .broadcast_pin(link.broadcast_pin), .sel_o(sel), .off_o(off),
    .pending_o(pend));
  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic mat;
    chk(32'(sel), 32'(exp_sel));
    chk(32'(off), 32'(exp_off));
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic bus(input logic wr, input logic [3:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk_sys_i);
    while (avs_waitrequest !== 1'b0 && n < 100) begin
      @(posedge clk_sys_i);
      n++;
    end
    if (n == 100) begin
      chk(32'(avs_waitrequest), 32'h0);
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic send(input logic [31:0] ctrl, input logic [31:0] d);
    int n;
    bus(1'b1, `XPC_REG_DATA, d);
    bus(1'b1, `XPC_REG_CTRL, ctrl);
    n = 0;
    q = 32'h1;
    while (q[0] !== 1'b0 && n < 200) begin
      bus(1'b0, `XPC_REG_STAT, 32'h0);
      n++;
    end
    idle(30);
  endtask
  task automatic load(input logic [15:0] v);
    for (int k = 0; k < 4; k++) begin
      exp_sel[3*k +: 3] = v[4*k +: 3];
      exp_off[k] = v[4*k+3];
    end
  endtask
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      finish_test();
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    idle(2);
    sys_rst_i <= 1'b0;
    idle(2);
    mat();
    idle(100);
    bus(1'b1, `XPC_REG_CTRL, 32'h0);
    idle(100);
    prev = 16'h0;
    for (int i = 0; i < 10; i++) begin
      rng = xs(rng);
      f = (i == 0) ? 16'h0000 : (i == 1) ? 16'hffff : rng[15:0];
      send(32'h11, 32'(f));
      load(f);
      mat();
      bus(1'b0, `XPC_REG_RX, 32'h0);
      if (i > 0) begin
        chk(32'(q[31:16]), 32'(prev));
      end
      prev = f;
    end
    $display("test serial done");
    for (int i = 0; i < 8; i++) begin
      rng = xs(rng);
      f = (i == 0) ? 16'h0023 : 16'(rng[5:0]);
      send(32'h13, 32'(f));
      exp_sel[3*f[1:0] +: 3] = f[4:2];
      exp_off[f[1:0]] = f[5];
      mat();
    end
    $display("test addressed done");
    rng = xs(rng);
    send(32'h01, rng);
    mat();
    chk(32'(pend), 32'h1);
    bus(1'b0, `XPC_REG_DATA, 32'h0);
    chk(q, rng);
    bus(1'b1, `XPC_REG_CTRL, 32'h20);
    idle(30);
    load(rng[15:0]);
    mat();
    chk(32'(pend), 32'h0);
    // Addressed mode here, so a stray load would move one output
    bus(1'b1, `XPC_REG_CTRL, 32'h22);
    idle(30);
    mat();
    $display("test configure done");
    bus(1'b1, `XPC_REG_CTRL, 32'h08);
    bus(1'b0, `XPC_REG_CTRL, 32'h0);
    chk(q, 32'h8);
    idle(20);
    exp_sel = 12'h000;
    exp_off = 4'h0;
    mat();
    bus(1'b1, `XPC_REG_CTRL, 32'h0c);
    idle(20);
    exp_off = 4'hf;
    mat();
    bus(1'b1, `XPC_REG_CTRL, 32'h04);
    idle(20);
    mat();
    bus(1'b1, `XPC_REG_CTRL, 32'h00);
    idle(20);
    mat();
    bus(1'b0, 4'h2, 32'h0);
    chk(q, 32'h0);
    $display("test special pins done");
    finish_test();
  end
endmodule
`default_nettype wire
